// ---- core/vfc_defs.svh ----
// Constants of the video forwarding control block: register indices,
// field positions, reset values and bus answers.
// Assumes it is included once per file by its bare name.
`ifndef VFC_DEFS_SVH
`define VFC_DEFS_SVH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define VFC_IDX_PORT_EN     8'h20
`define VFC_IDX_MODE_SEL    8'h21
`define VFC_IDX_LANE_CFG    8'h28
`define VFC_IDX_FWD_STATUS  8'h29

// ****************************************************************
// Field positions
// ****************************************************************
`define VFC_BIT_RX1_DIS     5
`define VFC_BIT_RX0_DIS     4
`define VFC_BIT_REPLICATE   7
`define VFC_BIT_SEND_READY  6
`define VFC_SYNC_HI         3
`define VFC_SYNC_LO         2
`define VFC_BIT_ROTATING    0
`define VFC_LANE0_HI        1
`define VFC_LANE0_LO        0
`define VFC_LANE1_HI        5
`define VFC_LANE1_LO        4

// ****************************************************************
// Writable masks and reset values
// ****************************************************************
`define VFC_PORT_EN_WMASK   8'hf0
`define VFC_MODE_SEL_WMASK  8'hcf
`define VFC_LANE_CFG_WMASK  8'h33
`define VFC_PORT_EN_RST     8'h30
`define VFC_MODE_SEL_RST    8'h01
`define VFC_LANE_CFG_RST    8'h11

// ****************************************************************
// Synchronized mode codes, lane limit, bus answers
// ****************************************************************
`define VFC_SYNC_OFF        2'h0
`define VFC_SYNC_BASIC      2'h1
`define VFC_SYNC_INTERLEAVE 2'h2
`define VFC_SYNC_CONCAT     2'h3
`define VFC_LANES_MAX_REP   2'h1
`define VFC_RESP_OKAY       2'h0
`define VFC_RESP_DECERR     2'h3

`endif

// ---- core/vfc_pkg.sv ----
// Types shared by the video forwarding control block.
// Assumes vfc_defs.svh for the numeric constants.
`default_nettype none
package vfc_pkg;

    // One receive port's offer of its next packet
    typedef struct packed {
        logic valid;      // A line or short packet is waiting
        logic short_pkt;  // Waiting item is a sync short packet
    } vfc_rx_t;

    // One forwarding job handed to the link side
    typedef struct packed {
        logic [1:0] mask;       // Ports whose items go out
        logic       short_pkt;  // Short packets rather than lines
        logic       concat;     // Lines joined into one
        logic       interleave; // Lines alternate by port
        logic       replicate;  // Copy output 0 onto output 1
    } vfc_job_t;

    // What one CSI output is told to send
    typedef struct packed {
        logic       start;      // One link-cycle pulse per job
        logic [1:0] mask;
        logic       short_pkt;
        logic       concat;
        logic       interleave;
    } vfc_tx_t;

    // Arbiter states
    typedef enum logic [0:0] {
        VFC_IDLE,
        VFC_WAIT_ACK
    } vfc_arb_state_t;

endpackage

`default_nettype wire

// ---- core/vfc_link_tx.sv ----
// Link-clock side of the forwarding engine: takes a held job, issues it
// to CSI output 0 and, in replicate mode, identically to output 1.
// Assumes the job is stable from its request toggle until the ack.
`timescale 1ns/1ps
`default_nettype none

module vfc_link_tx (
    input  wire logic              link_clk,
    input  wire logic              rst_b,
    input  wire vfc_pkg::vfc_job_t job,
    input  wire logic              req_tgl,
    output var  logic              ack_tgl,
    output var  vfc_pkg::vfc_tx_t  tx0,
    output var  vfc_pkg::vfc_tx_t  tx1
);
    import vfc_pkg::*;

    // ****************************************************************
    // Request crossing
    // ****************************************************************
    logic [2:0] req_sync;   // Three-stage synchroniser
    logic       req_seen;   // Last request level acted on
    logic       req_new;    // Settled request change

    // Shift the request toggle through three flops
    always_ff @(posedge link_clk or negedge rst_b) begin
        if (!rst_b) begin
            req_sync <= 3'h0;
        end else begin
            req_sync <= {req_sync[1:0], req_tgl};
        end
    end

    // A change counts once stages two and three agree
    assign req_new = (req_sync[1] == req_sync[2]) && (req_sync[2] != req_seen);

    // ****************************************************************
    // Output issue
    // ****************************************************************
    // Drive output 0 and mirror onto output 1 under replicate
    always_ff @(posedge link_clk or negedge rst_b) begin
        if (!rst_b) begin
            tx0      <= '0;
            tx1      <= '0;
            req_seen <= 1'b0;
            ack_tgl  <= 1'b0;
        end else begin
            tx0.start <= 1'b0;
            tx1.start <= 1'b0;
            if (req_new) begin
                req_seen <= req_sync[2];
                ack_tgl  <= ~ack_tgl;
                tx0      <= {1'b1, job.mask, job.short_pkt, job.concat, job.interleave};
                // Same content on output 1 when replicating
                if (job.replicate) begin
                    tx1 <= {1'b1, job.mask, job.short_pkt, job.concat, job.interleave};
                end
            end
        end
    end

endmodule

`default_nettype wire

// ---- core/vfc_top.sv ----
// Video forwarding control: register file over AXI4-Lite, arbiter that
// merges two receive ports onto CSI output 0, link-clock issue stage.
// Assumes receive ports and AXI master run on ref_clk, CSI on link_clk.
//
// Functional notes
// - Port 1 disable bit stops its forwarding.
// - Port 0 disable bit stops its forwarding.
// - Replicate copies output 0 onto output 1.
// - Replicate limits each output to two lanes.
// - Synchronized mode waits for all enabled ports.
// - Send-when-ready sends each line when available.
// - Send-when-ready ignored for concat and short packets.
// - Two-bit field selects the synchronized mode.
// - Rotating mode forwards without synchronizing ports.
// - Rotating mode grants ready ports in turn.
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "vfc_defs.svh"

module vfc_top (
    input  wire logic              ref_clk,
    input  wire logic              link_clk,
    input  wire logic              rst_b,
    // AXI4-Lite slave
    input  wire logic [7:0]        s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output var  logic              s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output var  logic              s_axi_wready,
    output var  logic [1:0]        s_axi_bresp,
    output var  logic              s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [7:0]        s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output var  logic              s_axi_arready,
    output var  logic [31:0]       s_axi_rdata,
    output var  logic [1:0]        s_axi_rresp,
    output var  logic              s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // Receive ports
    input  wire vfc_pkg::vfc_rx_t  rx0,
    input  wire vfc_pkg::vfc_rx_t  rx1,
    output var  logic [1:0]        rx_take,
    output var  logic [1:0]        rx_drop,
    // CSI outputs
    output var  logic [1:0]        out0_lanes,
    output var  logic [1:0]        out1_lanes,
    output var  vfc_pkg::vfc_tx_t  tx0,
    output var  vfc_pkg::vfc_tx_t  tx1
);
    import vfc_pkg::*;

    // ****************************************************************
    // Helpers
    // ****************************************************************
    // Byte address of a register index
    function automatic logic [7:0] reg_addr(input logic [7:0] idx);
        reg_addr = {idx[5:0], 2'b00};
    endfunction

    // Lane field limited to two lanes while replicating
    function automatic logic [1:0] lane_limit(input logic [1:0] f, input logic rep);
        lane_limit = (rep && f > `VFC_LANES_MAX_REP) ? `VFC_LANES_MAX_REP : f;
    endfunction

    // Rotating pick among ready ports, favouring the one not last served
    function automatic logic [1:0] rotate_pick(input logic [1:0] req, input logic last);
        if (req == 2'h3) begin
            rotate_pick = last ? 2'h1 : 2'h2;
        end else begin
            rotate_pick = req;
        end
    endfunction

    // ****************************************************************
    // Registers
    // ****************************************************************
    logic [7:0]     forwarding_port_enable; // Port disable bits
    logic [7:0]     forwarding_mode_select; // Mode bits
    logic [7:0]     lane_cfg;               // Lane count per output
    logic [7:0]     fwd_status;             // Engine state for reads
    logic           rx1_forward_disable;
    logic           rx0_forward_disable;
    logic           sync_send_when_ready;
    logic [1:0]     out0_synchronized_mode;
    logic           out0_rotating_mode;
    logic           replicate;

    assign rx1_forward_disable    = forwarding_port_enable[`VFC_BIT_RX1_DIS];
    assign rx0_forward_disable    = forwarding_port_enable[`VFC_BIT_RX0_DIS];
    assign replicate              = forwarding_mode_select[`VFC_BIT_REPLICATE];
    assign sync_send_when_ready   = forwarding_mode_select[`VFC_BIT_SEND_READY];
    assign out0_synchronized_mode = forwarding_mode_select[`VFC_SYNC_HI:`VFC_SYNC_LO];
    assign out0_rotating_mode     = forwarding_mode_select[`VFC_BIT_ROTATING];

    // ****************************************************************
    // AXI4-Lite write channel
    // ****************************************************************
    logic           aw_hold;    // Address taken, waiting for data
    logic           w_hold;     // Data taken, waiting for address
    logic [7:0]     aw_addr;    // Held write address
    logic [7:0]     w_data;     // Held low byte
    logic           w_lane0;    // Low byte lane strobed
    logic           wr_fire;    // Both halves here, commit now

    assign wr_fire = aw_hold && w_hold && !s_axi_bvalid;

    // Take address and data in either order, answer after both
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            aw_hold       <= 1'b0;
            w_hold        <= 1'b0;
            aw_addr       <= 8'h00;
            w_data        <= 8'h00;
            w_lane0       <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `VFC_RESP_OKAY;
        end else begin
            // Address handshake
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold       <= 1'b1;
                aw_addr       <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            // Data handshake
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold       <= 1'b1;
                w_data       <= s_axi_wdata[7:0];
                w_lane0      <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end
            // Commit and answer
            if (wr_fire) begin
                aw_hold      <= 1'b0;
                w_hold       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (aw_addr == reg_addr(`VFC_IDX_PORT_EN) ||
                    aw_addr == reg_addr(`VFC_IDX_MODE_SEL) ||
                    aw_addr == reg_addr(`VFC_IDX_LANE_CFG) ||
                    aw_addr == reg_addr(`VFC_IDX_FWD_STATUS)) begin
                    s_axi_bresp <= `VFC_RESP_OKAY;
                end else begin
                    s_axi_bresp <= `VFC_RESP_DECERR;
                end
            end
            // Response taken, reopen both channels
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Register update on commit; reserved read-only bits stay zero
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            forwarding_port_enable <= `VFC_PORT_EN_RST;
            forwarding_mode_select <= `VFC_MODE_SEL_RST;
            lane_cfg               <= `VFC_LANE_CFG_RST;
        end else if (wr_fire && w_lane0) begin
            if (aw_addr == reg_addr(`VFC_IDX_PORT_EN)) begin
                forwarding_port_enable <= w_data & `VFC_PORT_EN_WMASK;
            end
            if (aw_addr == reg_addr(`VFC_IDX_MODE_SEL)) begin
                forwarding_mode_select <= w_data & `VFC_MODE_SEL_WMASK;
            end
            if (aw_addr == reg_addr(`VFC_IDX_LANE_CFG)) begin
                lane_cfg <= w_data & `VFC_LANE_CFG_WMASK;
            end
        end
    end

    // ****************************************************************
    // AXI4-Lite read channel
    // ****************************************************************
    // One read at a time, data one cycle after the address
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= `VFC_RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= `VFC_RESP_OKAY;
                if (s_axi_araddr == reg_addr(`VFC_IDX_PORT_EN)) begin
                    s_axi_rdata <= {24'h0, forwarding_port_enable};
                end else if (s_axi_araddr == reg_addr(`VFC_IDX_MODE_SEL)) begin
                    s_axi_rdata <= {24'h0, forwarding_mode_select};
                end else if (s_axi_araddr == reg_addr(`VFC_IDX_LANE_CFG)) begin
                    s_axi_rdata <= {24'h0, lane_cfg};
                end else if (s_axi_araddr == reg_addr(`VFC_IDX_FWD_STATUS)) begin
                    s_axi_rdata <= {24'h0, fwd_status};
                end else begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= `VFC_RESP_DECERR;
                end
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // Lane configuration
    // ****************************************************************
    // Lane counts, held to two lanes while replicating
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            out0_lanes <= 2'h0;
            out1_lanes <= 2'h0;
        end else begin
            out0_lanes <= lane_limit(lane_cfg[`VFC_LANE0_HI:`VFC_LANE0_LO], replicate);
            out1_lanes <= lane_limit(lane_cfg[`VFC_LANE1_HI:`VFC_LANE1_LO], replicate);
        end
    end

    // ****************************************************************
    // Job decision
    // ****************************************************************
    logic [1:0]     enabled;    // Ports allowed to forward
    logic [1:0]     waiting;    // Ports offering an item
    logic [1:0]     avail;      // Enabled ports offering an item
    logic           any_short;  // A sync short packet is offered
    logic           sync_on;    // Synchronized forwarding active
    logic           all_ready;  // Every enabled port has an item
    vfc_job_t       next_job;   // Job chosen this cycle
    vfc_arb_state_t state;      // Arbiter state
    vfc_job_t       job;        // Job held for the link side
    logic           last_port;  // Port served last, for rotation
    logic           req_tgl;    // Request toggle to link side
    logic           ack_tgl;    // Ack toggle from link side

    assign enabled   = {~rx1_forward_disable, ~rx0_forward_disable};
    assign waiting   = {rx1.valid, rx0.valid};
    assign avail     = waiting & enabled;
    assign any_short = (rx0.valid && rx0.short_pkt) || (rx1.valid && rx1.short_pkt);
    // Rotating selection wins should software set both
    assign sync_on   = (out0_synchronized_mode != `VFC_SYNC_OFF) && !out0_rotating_mode;
    assign all_ready = (enabled != 2'h0) && (avail == enabled);

    // Choose which ports go out next
    always_comb begin
        next_job            = '0;
        next_job.replicate  = replicate;
        next_job.short_pkt  = any_short;
        next_job.concat     = (out0_synchronized_mode == `VFC_SYNC_CONCAT);
        next_job.interleave = (out0_synchronized_mode == `VFC_SYNC_INTERLEAVE);
        if (out0_rotating_mode) begin
            // No cross-port alignment, ports served in turn
            next_job.mask       = rotate_pick(avail, last_port);
            next_job.short_pkt  = next_job.mask[1] ? rx1.short_pkt : rx0.short_pkt;
            next_job.concat     = 1'b0;
            next_job.interleave = 1'b0;
        end else if (sync_on) begin
            if (sync_send_when_ready && !next_job.concat && !any_short) begin
                next_job.mask = avail;
            end else if (all_ready) begin
                next_job.mask = enabled;
            end
        end
    end

    // ****************************************************************
    // Arbiter and request crossing
    // ****************************************************************
    logic [2:0]     ack_sync;   // Three-stage synchroniser
    logic           ack_seen;   // Last ack level acted on
    logic           ack_new;    // Settled ack change

    // Shift the ack toggle through three flops
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ack_sync <= 3'h0;
        end else begin
            ack_sync <= {ack_sync[1:0], ack_tgl};
        end
    end

    assign ack_new = (ack_sync[1] == ack_sync[2]) && (ack_sync[2] != ack_seen);

    // Hold a job until the link side has issued it, then pop the lines
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state     <= VFC_IDLE;
            job       <= '0;
            req_tgl   <= 1'b0;
            ack_seen  <= 1'b0;
            last_port <= 1'b1;
            rx_take   <= 2'h0;
        end else begin
            rx_take <= 2'h0;
            unique case (state)
                VFC_IDLE: begin
                    // Issue only when a port was chosen
                    if (next_job.mask != 2'h0 && rx_take == 2'h0) begin
                        job     <= next_job;
                        req_tgl <= ~req_tgl;
                        state   <= VFC_WAIT_ACK;
                        if (next_job.mask != 2'h3) begin
                            last_port <= next_job.mask[1];
                        end
                    end
                end
                VFC_WAIT_ACK: begin
                    // Items sent, release them at the ports
                    if (ack_new) begin
                        ack_seen <= ack_sync[2];
                        rx_take  <= job.mask;
                        state    <= VFC_IDLE;
                    end
                end
            endcase
        end
    end

    // Discard items offered on disabled ports, one pulse per item
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_drop <= 2'h0;
        end else begin
            rx_drop <= waiting & ~enabled & ~rx_drop;
        end
    end

    // Readable engine state: busy, sync active, last job ports
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            fwd_status <= 8'h00;
        end else begin
            fwd_status <= {4'h0, job.mask, sync_on, (state == VFC_WAIT_ACK)};
        end
    end

    // ****************************************************************
    // Link-clock issue stage
    // ****************************************************************
    vfc_link_tx u_link_tx (
        .link_clk (link_clk),
        .rst_b    (rst_b),
        .job      (job),
        .req_tgl  (req_tgl),
        .ack_tgl  (ack_tgl),
        .tx0      (tx0),
        .tx1      (tx1)
    );

endmodule

`default_nettype wire

// ---- verif/vfc_checker.sv ----
// Port checker for the forwarding control block.
// Assumes bind to vfc_top; both clocks share rst_b.
`timescale 1ns/1ps
`default_nettype none
module vfc_checker (
    input wire logic             ref_clk,
    input wire logic             link_clk,
    input wire logic             rst_b,
    input wire vfc_pkg::vfc_rx_t rx0,
    input wire vfc_pkg::vfc_rx_t rx1,
    input wire logic [1:0]       rx_take,
    input wire logic [1:0]       rx_drop,
    input wire logic [1:0]       out0_lanes,
    input wire logic [1:0]       out1_lanes,
    input wire vfc_pkg::vfc_tx_t tx0,
    input wire vfc_pkg::vfc_tx_t tx1
);
    import vfc_pkg::*;
    // Any forwarding grant
    sequence s_take;
        rx_take != 2'h0;
    endsequence
    a_take_port0: assert property (@(posedge ref_clk) disable iff (!rst_b)
        rx_take[0] |-> rx0.valid) else $error("take0 idle");
    a_take_port1: assert property (@(posedge ref_clk) disable iff (!rst_b)
        rx_take[1] |-> rx1.valid) else $error("take1 idle");
    a_drop_port0: assert property (@(posedge ref_clk) disable iff (!rst_b)
        rx_drop[0] |-> rx0.valid) else $error("drop0 idle");
    a_drop_port1: assert property (@(posedge ref_clk) disable iff (!rst_b)
        rx_drop[1] |-> rx1.valid) else $error("drop1 idle");
    a_drop_gap: assert property (@(posedge ref_clk) disable iff (!rst_b)
        rx_drop[0] |=> !rx_drop[0]) else $error("drop0 twice");
    a_take_gap: assert property (@(posedge ref_clk) disable iff (!rst_b)
        s_take |=> rx_take == 2'h0) else $error("take twice");
    a_rep_copy: assert property (@(posedge link_clk) disable iff (!rst_b)
        tx1.start |-> tx1 == tx0) else $error("copy differs");
    a_rep_lanes: assert property (@(posedge link_clk) disable iff (!rst_b)
        tx1.start |-> out0_lanes <= 2'h1 && out1_lanes <= 2'h1) else $error("lanes too wide");
endmodule
bind vfc_top vfc_checker vfc_checker_inst (.ref_clk, .link_clk, .rst_b, .rx0, .rx1,
    .rx_take, .rx_drop, .out0_lanes, .out1_lanes, .tx0, .tx1);
`default_nettype wire

// ---- verif/vfc_csi_sink.sv ----
// Downstream CSI receiver model: counts jobs per output.
// Assumes tx0/tx1 from vfc_top on link_clk.
`timescale 1ns/1ps
`default_nettype none
module vfc_csi_sink (
    input  wire logic             link_clk,
    input  wire logic             rst_b,
    input  wire vfc_pkg::vfc_tx_t tx0,
    input  wire vfc_pkg::vfc_tx_t tx1,
    output var  int               n0,
    output var  int               n1,
    output var  vfc_pkg::vfc_tx_t last0,
    output var  vfc_pkg::vfc_tx_t last1
);
    import vfc_pkg::*;
    // Accepts every job promptly on either output
    always_ff @(posedge link_clk or negedge rst_b) begin
        if (!rst_b) begin
            n0 <= 0; n1 <= 0; last0 <= '0; last1 <= '0;
        end else begin
            if (tx0.start) begin n0 <= n0 + 1; last0 <= tx0; end
            if (tx1.start) begin n1 <= n1 + 1; last1 <= tx1; end
        end
    end
endmodule
`default_nettype wire

// ---- verif/test_video_forwarding_control.sv ----
// Testbench for vfc_top with AXI4-Lite master and CSI sink.
// Assumes vfc_pkg, vfc_csi_sink and vfc_checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_video_forwarding_control;
    import vfc_pkg::*;
    logic ref_clk = 0, link_clk = 0, rst_b = 0;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rx_take, rx_drop, out0_lanes, out1_lanes;
    vfc_rx_t rx0 = '0, rx1 = '0;
    vfc_tx_t tx0, tx1, last0, last1;
    int n0, n1, mismatches = 0, checks = 0;
    vfc_top vfc_top_inst (.ref_clk, .link_clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .rx0, .rx1, .rx_take, .rx_drop, .out0_lanes, .out1_lanes, .tx0, .tx1);
    vfc_csi_sink vfc_csi_sink_inst (.link_clk, .rst_b, .tx0, .tx1, .n0, .n1, .last0, .last1);
    initial forever #4 ref_clk = ~ref_clk;
    initial begin #1.7; forever #3 link_clk = ~link_clk; end
    task cmp(input string n, input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin mismatches++; $display("ERROR %s expected %h seen %h", n, e, g); end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        s_axi_awaddr <= a; s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
        do begin
            @(posedge ref_clk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 0;
        cmp("bresp", s_axi_bresp, 2'h0);
    endtask
    task rd(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er);
        @(posedge ref_clk);
        s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
        do begin @(posedge ref_clk); if (s_axi_arready) s_axi_arvalid <= 0; end while (!s_axi_rvalid);
        s_axi_rready <= 0;
        cmp("rdata", s_axi_rdata, {24'h0, ed});
        cmp("rresp", s_axi_rresp, er);
    endtask
    // Offer items, pop each on take or drop, and judge grants
    task go(input logic [1:0] v, input logic s, input logic [1:0] ef, ex, ed);
        logic [1:0] first, tk, dr;
        first = 0; tk = 0; dr = 0;
        @(posedge ref_clk);
        rx0 <= '{v[0], s}; rx1 <= '{v[1], s};
        repeat (60) begin
            @(posedge ref_clk);
            if (first === 2'h0) first = rx_take;
            tk |= rx_take; dr |= rx_drop;
            if (rx_take[0] | rx_drop[0]) rx0.valid <= 0;
            if (rx_take[1] | rx_drop[1]) rx1.valid <= 0;
        end
        @(posedge ref_clk);
        rx0 <= '0; rx1 <= '0;
        cmp("first", first, ef); cmp("take", tk, ex); cmp("drop", dr, ed);
    endtask
    task t_regs;
        rd(8'h80, 8'h30, 2'h0); rd(8'h84, 8'h01, 2'h0);
        rd(8'ha0, 8'h11, 2'h0); rd(8'hfc, 8'h00, 2'h3);
        rd(8'ha4, 8'h00, 2'h0);
        wr(8'h80, 8'hff); rd(8'h80, 8'hf0, 2'h0);
    endtask
    task t_drop;
        go(2'h3, 0, 2'h0, 2'h0, 2'h3);
        wr(8'h80, 8'h20); go(2'h3, 0, 2'h1, 2'h1, 2'h2);
        wr(8'h80, 8'h00);
    endtask
    task t_rotate;
        go(2'h3, 0, 2'h2, 2'h3, 2'h0);
        go(2'h2, 0, 2'h2, 2'h2, 2'h0);
    endtask
    task t_sync;
        wr(8'h84, 8'h04); go(2'h1, 0, 2'h0, 2'h0, 2'h0);
        wr(8'h84, 8'h4c); go(2'h1, 0, 2'h0, 2'h0, 2'h0);
        wr(8'h84, 8'h44); go(2'h1, 1, 2'h0, 2'h0, 2'h0);
        go(2'h1, 0, 2'h1, 2'h1, 2'h0);
        for (int m = 1; m < 4; m++) begin
            wr(8'h84, 8'(m << 2)); go(2'h3, 0, 2'h3, 2'h3, 2'h0);
            cmp("mode", {last0.mask, last0.concat, last0.interleave}, {2'h3, m == 3, m == 2});
        end
    endtask
    task t_replicate;
        wr(8'ha0, 8'h33); wr(8'h84, 8'h81);
        @(posedge ref_clk);
        cmp("lanes", {out0_lanes, out1_lanes}, 4'h5);
        go(2'h1, 0, 2'h1, 2'h1, 2'h0);
        cmp("copies", n1, 1); cmp("copy", last1, last0);
        wr(8'h84, 8'h01);
        @(posedge ref_clk);
        cmp("lanes0", out0_lanes, 2'h3);
    endtask
    task report_and_stop;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin repeat (20000) @(posedge ref_clk); mismatches++; report_and_stop; end
    initial begin
        repeat (5) @(posedge ref_clk);
        rst_b <= 1;
        t_regs; t_drop; t_rotate; t_sync; t_replicate;
        report_and_stop;
    end
endmodule
`default_nettype wire
